//--- hdl/tpc_map.vh
`ifndef TPC_MAP_VH
`define TPC_MAP_VH

// Register byte addresses on the AXI4-Lite slave, one aligned word each.
`define TPC_ADDR_STATUS_CTRL 8'h00
`define TPC_ADDR_COUNT_HIGH 8'h04
`define TPC_ADDR_COUNT_LOW 8'h08
`define TPC_ADDR_MODULO_HIGH 8'h0c
`define TPC_ADDR_MODULO_LOW 8'h10

// Field positions in the status/control register.
`define TPC_BIT_OVF_FLAG 7
`define TPC_BIT_OVF_IRQ_EN 6
`define TPC_BIT_CENTER_SEL 5
`define TPC_CLKSRC_HI 4
`define TPC_CLKSRC_LO 3
`define TPC_PRESCALE_HI 2
`define TPC_PRESCALE_LO 0

// Clock source field encodings.
`define TPC_CLKSRC_NONE 2'h0
`define TPC_CLKSRC_BUS 2'h1
`define TPC_CLKSRC_FIXED 2'h2
`define TPC_CLKSRC_EXT 2'h3

// Reset values and the full-range count limit.
`define TPC_RST_STATUS_CTRL 8'h00
`define TPC_RST_COUNT 16'h0000
`define TPC_RST_MODULO 16'h0000
`define TPC_COUNT_TOP 16'hffff

// AXI response codes.
`define TPC_RESP_OKAY 2'h0
`define TPC_RESP_SLVERR 2'h2

// Timing: synchroniser depth in bus clock cycles before edge detection.
`define TPC_SYNC_STAGES 2

`endif

//--- hdl/tpc_clk_source.v
`timescale 1ns/1ps
`include "tpc_map.vh"

module tpc_clk_source (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [1:0] sel,
  input wire fixed_clk_in,
  input wire ext_clk_in,
  output reg src_tick
);

  reg [1:0] fixed_sync_q;
  reg [1:0] ext_sync_q;
  reg fixed_prev_q;
  reg ext_prev_q;

  // Both slow clocks are sampled by the bus clock; only the second stage feeds edge detection.
  always @(posedge clk) begin
    if (rst) begin
      fixed_sync_q <= 2'h0;
      ext_sync_q <= 2'h0;
      fixed_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else if (ce) begin
      fixed_sync_q <= {fixed_sync_q[0], fixed_clk_in};
      ext_sync_q <= {ext_sync_q[0], ext_clk_in};
      fixed_prev_q <= fixed_sync_q[1];
      ext_prev_q <= ext_sync_q[1];
    end
  end

  // Each rising edge of a slow source counts once; the bus source ticks every cycle.
  always @* begin
    case (sel)
      `TPC_CLKSRC_BUS: src_tick = 1'b1;
      `TPC_CLKSRC_FIXED: src_tick = fixed_sync_q[1] & ~fixed_prev_q;
      `TPC_CLKSRC_EXT: src_tick = ext_sync_q[1] & ~ext_prev_q;
      default: src_tick = 1'b0;
    endcase
  end

endmodule // tpc_clk_source

//--- hdl/tpc_prescaler.v
`timescale 1ns/1ps

module tpc_prescaler #(
  parameter PS_WIDTH = 3
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire clear,
  input wire src_tick,
  input wire [PS_WIDTH-1:0] ps,
  output wire tick
);

  localparam DIV_WIDTH = (1 << PS_WIDTH) - 1;

  reg [DIV_WIDTH-1:0] div_q;
  wire [DIV_WIDTH-1:0] mask;

  genvar i;
  generate
    for (i = 0; i < DIV_WIDTH; i = i + 1) begin : g_mask
      assign mask[i] = (i < ps);
    end
  endgenerate

  // Divide by two to the power of ps: the tick fires when the low ps bits are all ones.
  assign tick = src_tick & ((div_q & mask) == mask);

  // The divider sits after source selection, so it applies to any source.
  always @(posedge clk) begin
    if (rst) begin
      div_q <= {DIV_WIDTH{1'b0}};
    end else if (ce) begin
      if (clear) begin
        div_q <= {DIV_WIDTH{1'b0}};
      end else if (src_tick) begin
        div_q <= div_q + {{(DIV_WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // tpc_prescaler

//--- hdl/tpc_timer_core.v
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "tpc_map.vh"

module tpc_timer_core (
  input wire SYS_CLK,
  input wire RST,
  input wire CLK_EN,
  input wire DEBUG_ACTIVE,
  input wire FIXED_CLK_IN,
  input wire EXT_CLK_IN,
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  output reg OVF_IRQ,
  output reg [15:0] COUNT_VALUE,
  output reg CENTER_ALIGNED
);

  localparam CNT_WIDTH = 16;

  // Status/control fields and counter state.
  reg ovf_flag_q;
  reg ovf_flag_d;
  reg ovf_irq_en_q;
  reg center_sel_q;
  reg [1:0] clk_src_q;
  reg [2:0] prescale_q;
  reg clear_armed_q;
  reg clear_armed_d;
  reg count_down_q;
  reg [CNT_WIDTH-1:0] modulo_q;
  reg [7:0] mod_high_buf_q;
  reg [7:0] mod_low_buf_q;
  reg mod_high_seen_q;
  reg mod_low_seen_q;
  reg mod_pending_q;
  reg [CNT_WIDTH-1:0] cnt_latch_q;
  reg latched_q;
  reg latch_first_high_q;

  // Bus write channel holding state.
  reg [7:0] aw_addr_q;
  reg aw_held_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg w_held_q;

  wire src_tick;
  wire timer_tick;
  wire [CNT_WIDTH-1:0] count_top;
  wire at_top;
  wire wr_fire;
  wire wr_lane0;
  wire rd_fire;
  wire wr_status;
  wire wr_count;
  wire wr_mod_high;
  wire wr_mod_low;
  wire rd_status;
  wire rd_count_high;
  wire rd_count_low;
  wire cnt_run;
  wire ovf_raw;
  wire ovf_event;
  wire [7:0] status_word;

  tpc_clk_source u_clk_source (
    .clk(SYS_CLK),
    .rst(RST),
    .ce(CLK_EN),
    .sel(clk_src_q),
    .fixed_clk_in(FIXED_CLK_IN),
    .ext_clk_in(EXT_CLK_IN),
    .src_tick(src_tick)
  );

  tpc_prescaler #(
    .PS_WIDTH(3)
  ) u_prescaler (
    .clk(SYS_CLK),
    .rst(RST),
    .ce(CLK_EN),
    .clear(wr_count),
    .src_tick(src_tick),
    .ps(prescale_q),
    .tick(timer_tick)
  );

  // A write happens once both address and data are held and no response is pending.
  assign wr_fire = aw_held_q & w_held_q & ~S_AXI_BVALID;
  assign wr_lane0 = w_strb_q[0];
  assign rd_fire = S_AXI_ARVALID & S_AXI_ARREADY;

  assign wr_status = wr_fire & wr_lane0 & (aw_addr_q == `TPC_ADDR_STATUS_CTRL);
  assign wr_count = wr_fire & wr_lane0 &
    ((aw_addr_q == `TPC_ADDR_COUNT_HIGH) | (aw_addr_q == `TPC_ADDR_COUNT_LOW));
  assign wr_mod_high = wr_fire & wr_lane0 & (aw_addr_q == `TPC_ADDR_MODULO_HIGH);
  assign wr_mod_low = wr_fire & wr_lane0 & (aw_addr_q == `TPC_ADDR_MODULO_LOW);
  assign rd_status = rd_fire & ({S_AXI_ARADDR[7:2], 2'h0} == `TPC_ADDR_STATUS_CTRL);
  assign rd_count_high = rd_fire & ({S_AXI_ARADDR[7:2], 2'h0} == `TPC_ADDR_COUNT_HIGH);
  assign rd_count_low = rd_fire & ({S_AXI_ARADDR[7:2], 2'h0} == `TPC_ADDR_COUNT_LOW);

  // Modulo zero disables the limit and lets the counter use its full range.
  assign count_top = (modulo_q == `TPC_RST_MODULO) ? `TPC_COUNT_TOP : modulo_q;
  assign at_top = (COUNT_VALUE == count_top);

  // Source none leaves the tick low, so the timer is disabled.
  // Debug mode holds the counter where it stood at entry.
  assign cnt_run = timer_tick & ~DEBUG_ACTIVE & ~wr_count;

  // Up mode overflows on the roll to zero; centre mode on the turn downward.
  assign ovf_raw = cnt_run & at_top & ~count_down_q;
  // A half-written modulo suppresses the overflow flag and its interrupt.
  assign ovf_event = ovf_raw & ~mod_pending_q;

  assign status_word = {ovf_flag_q, ovf_irq_en_q, center_sel_q, clk_src_q, prescale_q};

  // Flag clear sequence; a set in the same cycle as the clearing write wins.
  always @* begin
    ovf_flag_d = ovf_flag_q;
    clear_armed_d = clear_armed_q;
    if (rd_status & ovf_flag_q) begin
      clear_armed_d = 1'b1;
    end
    if (wr_status & ~w_data_q[`TPC_BIT_OVF_FLAG] & clear_armed_q) begin
      ovf_flag_d = 1'b0;
      clear_armed_d = 1'b0;
    end
    // Writing a one to the flag falls through here with no effect.
    if (ovf_event) begin
      ovf_flag_d = 1'b1;
      clear_armed_d = 1'b0;
    end
  end

  // Status/control register, interrupt and mode outputs.
  always @(posedge SYS_CLK) begin
    if (RST) begin
      ovf_flag_q <= 1'b0;
      clear_armed_q <= 1'b0;
      ovf_irq_en_q <= 1'b0;
      center_sel_q <= 1'b0;
      clk_src_q <= `TPC_CLKSRC_NONE;
      prescale_q <= 3'h0;
      OVF_IRQ <= 1'b0;
      CENTER_ALIGNED <= 1'b0;
    end else if (CLK_EN) begin
      ovf_flag_q <= ovf_flag_d;
      clear_armed_q <= clear_armed_d;
      if (wr_status) begin
        ovf_irq_en_q <= w_data_q[`TPC_BIT_OVF_IRQ_EN];
        center_sel_q <= w_data_q[`TPC_BIT_CENTER_SEL];
        clk_src_q <= w_data_q[`TPC_CLKSRC_HI:`TPC_CLKSRC_LO];
        prescale_q <= w_data_q[`TPC_PRESCALE_HI:`TPC_PRESCALE_LO];
        OVF_IRQ <= ovf_flag_d & w_data_q[`TPC_BIT_OVF_IRQ_EN];
        CENTER_ALIGNED <= w_data_q[`TPC_BIT_CENTER_SEL];
      end else begin
        OVF_IRQ <= ovf_flag_d & ovf_irq_en_q;
      end
    end
  end

  // Counter: up-counting or up/down in centre-aligned mode.
  always @(posedge SYS_CLK) begin
    if (RST) begin
      COUNT_VALUE <= `TPC_RST_COUNT;
      count_down_q <= 1'b0;
    end else if (CLK_EN) begin
      if (wr_count) begin
        COUNT_VALUE <= `TPC_RST_COUNT;
        count_down_q <= 1'b0;
      end else if (cnt_run) begin
        if (~center_sel_q) begin
          count_down_q <= 1'b0;
          if (at_top) begin
            COUNT_VALUE <= `TPC_RST_COUNT;
          end else begin
            COUNT_VALUE <= COUNT_VALUE + 16'h0001;
          end
        end else if (count_down_q) begin
          if (COUNT_VALUE == `TPC_RST_COUNT) begin
            count_down_q <= 1'b0;
            COUNT_VALUE <= 16'h0001;
          end else begin
            COUNT_VALUE <= COUNT_VALUE - 16'h0001;
          end
        end else if (at_top) begin
          count_down_q <= 1'b1;
          COUNT_VALUE <= COUNT_VALUE - 16'h0001;
        end else begin
          COUNT_VALUE <= COUNT_VALUE + 16'h0001;
        end
      end
    end
  end

  // Modulo register takes effect only once both bytes have been written.
  // Holding the first byte avoids a half-updated compare value mid-period.
  always @(posedge SYS_CLK) begin
    if (RST) begin
      modulo_q <= `TPC_RST_MODULO;
      mod_high_buf_q <= 8'h00;
      mod_low_buf_q <= 8'h00;
      mod_high_seen_q <= 1'b0;
      mod_low_seen_q <= 1'b0;
      mod_pending_q <= 1'b0;
    end else if (CLK_EN) begin
      if (wr_mod_high) begin
        mod_high_buf_q <= w_data_q[7:0];
        if (mod_low_seen_q) begin
          modulo_q <= {w_data_q[7:0], mod_low_buf_q};
          mod_low_seen_q <= 1'b0;
          mod_pending_q <= 1'b0;
        end else begin
          mod_high_seen_q <= 1'b1;
          mod_pending_q <= 1'b1;
        end
      end else if (wr_mod_low) begin
        mod_low_buf_q <= w_data_q[7:0];
        if (mod_high_seen_q) begin
          modulo_q <= {mod_high_buf_q, w_data_q[7:0]};
          mod_high_seen_q <= 1'b0;
          mod_pending_q <= 1'b0;
        end else begin
          mod_low_seen_q <= 1'b1;
          mod_pending_q <= 1'b1;
        end
      end
    end
  end

  // Counter read coherency: the first byte read snapshots both bytes.
  always @(posedge SYS_CLK) begin
    if (RST) begin
      cnt_latch_q <= `TPC_RST_COUNT;
      latched_q <= 1'b0;
      latch_first_high_q <= 1'b0;
    end else if (CLK_EN) begin
      if (wr_count | wr_status) begin
        latched_q <= 1'b0;
      end else if (~DEBUG_ACTIVE & (rd_count_high | rd_count_low)) begin
        if (~latched_q) begin
          cnt_latch_q <= COUNT_VALUE;
          latched_q <= 1'b1;
          latch_first_high_q <= rd_count_high;
        end else if (rd_count_high != latch_first_high_q) begin
          latched_q <= 1'b0;
        end
      end
      // In debug mode reads leave the latches untouched.
    end
  end

  // AXI4-Lite write channels: address and data accepted in either order.
  always @(posedge SYS_CLK) begin
    if (RST) begin
      aw_addr_q <= 8'h00;
      aw_held_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      w_held_q <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `TPC_RESP_OKAY;
    end else if (CLK_EN) begin
      S_AXI_AWREADY <= ~aw_held_q & ~(S_AXI_AWVALID & S_AXI_AWREADY);
      S_AXI_WREADY <= ~w_held_q & ~(S_AXI_WVALID & S_AXI_WREADY);
      if (S_AXI_AWVALID & S_AXI_AWREADY) begin
        aw_addr_q <= {S_AXI_AWADDR[7:2], 2'h0};
        aw_held_q <= 1'b1;
      end
      if (S_AXI_WVALID & S_AXI_WREADY) begin
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
        w_held_q <= 1'b1;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        case (aw_addr_q)
          `TPC_ADDR_STATUS_CTRL, `TPC_ADDR_COUNT_HIGH, `TPC_ADDR_COUNT_LOW,
          `TPC_ADDR_MODULO_HIGH, `TPC_ADDR_MODULO_LOW: S_AXI_BRESP <= `TPC_RESP_OKAY;
          default: S_AXI_BRESP <= `TPC_RESP_SLVERR;
        endcase
      end else if (S_AXI_BVALID & S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel: one read in flight, data registered with the response.
  always @(posedge SYS_CLK) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `TPC_RESP_OKAY;
    end else if (CLK_EN) begin
      if (rd_fire) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= `TPC_RESP_OKAY;
        case ({S_AXI_ARADDR[7:2], 2'h0})
          `TPC_ADDR_STATUS_CTRL: S_AXI_RDATA <= {24'h000000, status_word};
          `TPC_ADDR_COUNT_HIGH: S_AXI_RDATA <= {24'h000000,
            latched_q ? cnt_latch_q[15:8] : COUNT_VALUE[15:8]};
          `TPC_ADDR_COUNT_LOW: S_AXI_RDATA <= {24'h000000,
            latched_q ? cnt_latch_q[7:0] : COUNT_VALUE[7:0]};
          `TPC_ADDR_MODULO_HIGH: S_AXI_RDATA <= {24'h000000, modulo_q[15:8]};
          `TPC_ADDR_MODULO_LOW: S_AXI_RDATA <= {24'h000000, modulo_q[7:0]};
          default: begin
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= `TPC_RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_RVALID & S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end else begin
        S_AXI_ARREADY <= ~S_AXI_RVALID;
      end
    end
  end

endmodule // tpc_timer_core

//--- tb/tpc_timer_core_props.sv
`timescale 1ns/1ps
module tpc_timer_core_props (
  input wire SYS_CLK,
  input wire RST,
  input wire CLK_EN,
  input wire DEBUG_ACTIVE,
  input wire S_AXI_AWVALID,
  input wire S_AXI_AWREADY,
  input wire S_AXI_WVALID,
  input wire S_AXI_WREADY,
  input wire S_AXI_BVALID,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire S_AXI_RVALID,
  input wire OVF_IRQ,
  input wire [15:0] COUNT_VALUE,
  input wire CENTER_ALIGNED
);
  default clocking dcb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  // A register write lands one edge before the sample where BVALID is first seen high.
  AST_CNT_RESET: assert property ($fell(RST) |-> COUNT_VALUE == 16'h0000 && !OVF_IRQ)
    else $error("counter or irq not clear after reset");
  AST_OVF_CAUSE: assert property ($rose(OVF_IRQ) && !$rose(S_AXI_BVALID) |->
    (CENTER_ALIGNED ? COUNT_VALUE < $past(COUNT_VALUE) : COUNT_VALUE == 16'h0000))
    else $error("irq rose without an overflow step");
  AST_IRQ_DROP: assert property ($fell(OVF_IRQ) |-> $rose(S_AXI_BVALID))
    else $error("irq dropped without a register write");
  AST_CENTER_COPY: assert property ($changed(CENTER_ALIGNED) |-> $rose(S_AXI_BVALID))
    else $error("centre output moved without a write");
  AST_UP_STEP: assert property (!CENTER_ALIGNED && !$past(CENTER_ALIGNED) &&
    !$rose(S_AXI_BVALID) |-> COUNT_VALUE == $past(COUNT_VALUE) ||
    COUNT_VALUE == $past(COUNT_VALUE) + 16'h0001 || COUNT_VALUE == 16'h0000)
    else $error("up counter made an illegal step");
  AST_CENTER_STEP: assert property (CENTER_ALIGNED && $past(CENTER_ALIGNED) &&
    !$rose(S_AXI_BVALID) && $changed(COUNT_VALUE) |->
    COUNT_VALUE == $past(COUNT_VALUE) + 16'h0001 || COUNT_VALUE == $past(COUNT_VALUE) - 16'h0001)
    else $error("up/down counter moved by more than one");
  AST_FREEZE: assert property (($past(DEBUG_ACTIVE) || !$past(CLK_EN)) &&
    !$rose(S_AXI_BVALID) |-> $stable(COUNT_VALUE))
    else $error("counter moved while frozen");
  AST_RD_LAT: assert property (S_AXI_ARVALID && S_AXI_ARREADY && CLK_EN |=> S_AXI_RVALID)
    else $error("read answer late");
  AST_WR_LAT: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |-> ##2 S_AXI_BVALID)
    else $error("write answer late");
  COV_IRQ: cover property ($rose(OVF_IRQ));
  COV_CENTER: cover property (CENTER_ALIGNED && $changed(COUNT_VALUE));
  COV_DEBUG: cover property (DEBUG_ACTIVE [*8]);
endmodule // tpc_timer_core_props

bind tpc_timer_core tpc_timer_core_props tpc_timer_core_props_i (
  .SYS_CLK(SYS_CLK),
  .RST(RST),
  .CLK_EN(CLK_EN),
  .DEBUG_ACTIVE(DEBUG_ACTIVE),
  .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID),
  .OVF_IRQ(OVF_IRQ),
  .COUNT_VALUE(COUNT_VALUE),
  .CENTER_ALIGNED(CENTER_ALIGNED)
);

//--- tb/tpc_timer_core_tb.sv
`timescale 1ns/1ps
`include "tpc_map.vh"
module tpc_timer_core_tb;
  localparam logic [7:0] a_sc = `TPC_ADDR_STATUS_CTRL, a_ch = `TPC_ADDR_COUNT_HIGH;
  localparam logic [7:0] a_cl = `TPC_ADDR_COUNT_LOW, a_mh = `TPC_ADDR_MODULO_HIGH;
  localparam logic [7:0] a_ml = `TPC_ADDR_MODULO_LOW;
  logic clk = 0, rst = 1, clk_en = 1, dbg = 0, fix_clk = 0, ext_clk = 0;
  logic [7:0] aw_addr = 0, ar_addr = 0;
  logic aw_vld = 0, w_vld = 0, b_rdy = 0, ar_vld = 0, r_rdy = 0;
  logic [31:0] w_data = 0, rd;
  wire aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, irq, ctr;
  wire [1:0] b_resp, r_resp;
  wire [31:0] r_data;
  wire [15:0] cnt;
  logic [1:0] rs;
  logic [15:0] m, v, lo, hi;
  int failures = 0, checks = 0;
  always #5 clk = ~clk;
  // Pin clocks stay well under a quarter of the bus clock.
  always begin
    repeat (4) @(posedge clk);
    fix_clk <= ~fix_clk;
  end
  // No channel shares the pin clock input here, so no edge/level bits need clearing.
  always begin
    repeat (5) @(posedge clk);
    ext_clk <= ~ext_clk;
  end
  tpc_timer_core tpc_timer_core_i (.SYS_CLK(clk), .RST(rst), .CLK_EN(clk_en),
    .DEBUG_ACTIVE(dbg), .FIXED_CLK_IN(fix_clk), .EXT_CLK_IN(ext_clk), .S_AXI_AWADDR(aw_addr),
    .S_AXI_AWVALID(aw_vld), .S_AXI_AWREADY(aw_rdy), .S_AXI_WDATA(w_data), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(w_vld), .S_AXI_WREADY(w_rdy), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_vld),
    .S_AXI_BREADY(b_rdy), .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_vld),
    .S_AXI_ARREADY(ar_rdy), .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_vld),
    .S_AXI_RREADY(r_rdy), .OVF_IRQ(irq), .COUNT_VALUE(cnt), .CENTER_ALIGNED(ctr));
  function int per(input logic [1:0] s, input logic [2:0] p);
    per = (s == 2'h1 ? 1 : s == 2'h2 ? 8 : 10) << p;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
    end
  endtask
  task chk_resp(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t response %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w;
    aw = 1;
    w = 1;
    @(posedge clk);
    aw_addr <= a;
    w_data <= {24'h0, d};
    aw_vld <= 1;
    w_vld <= 1;
    b_rdy <= 1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && aw_rdy === 1'b1) begin
        aw = 0;
        aw_vld <= 0;
      end
      if (w && w_rdy === 1'b1) begin
        w = 0;
        w_vld <= 0;
      end
    end
    do @(posedge clk); while (b_vld !== 1'b1);
    rs = b_resp;
    b_rdy <= 0;
  endtask
  task rdr(input logic [7:0] a);
    @(posedge clk);
    ar_addr <= a;
    ar_vld <= 1;
    r_rdy <= 1;
    do @(posedge clk); while (ar_rdy !== 1'b1);
    ar_vld <= 0;
    do @(posedge clk); while (r_vld !== 1'b1);
    rd = r_data;
    rs = r_resp;
    r_rdy <= 0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    rdr(a);
    chk(rd, e);
    chk_resp(rs, `TPC_RESP_OKAY);
  endtask
  // The first tick after a source change may carry an old divider phase, so skip it.
  task meas(input logic [1:0] s, input logic [2:0] p);
    int n;
    wr(a_sc, {3'h0, s, p});
    repeat (2) begin
      v = cnt;
      do @(posedge clk); while (cnt === v);
    end
    v = cnt;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cnt === v);
    chk(n, per(s, p));
  endtask
  task pair(input logic lf);
    v = cnt;
    rdr(lf ? a_cl : a_ch);
    lo = rd[15:0];
    repeat (300) @(posedge clk);
    rdr(lf ? a_ch : a_cl);
    hi = lf ? {rd[7:0], lo[7:0]} : {lo[7:0], rd[7:0]};
    chk(16'(hi - v) < 16'h8, 1'b1);
  endtask
  task ovf(input logic [15:0] e);
    do @(posedge clk); while (cnt !== m);
    @(posedge clk);
    chk(cnt, e);
    chk(irq, 1'b1);
  endtask
  task fin(input string s);
    $display("test %s done, checks %0d", s, checks);
  endtask
  task final_report;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    final_report;
  end
  initial begin
    void'($urandom(32'hb178));
    repeat (16) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 5; i++) rchk(8'(i * 4), 32'h0);
    rdr(8'h14);
    chk(rd, 32'h0);
    chk_resp(rs, `TPC_RESP_SLVERR);
    wr(8'h14, 8'hff);
    chk_resp(rs, `TPC_RESP_SLVERR);
    fin("reset");
    v = cnt;
    repeat (40) @(posedge clk);
    chk(cnt, v);
    for (int p = 0; p < 8; p++) meas(2'h1, p[2:0]);
    meas(2'h2, 3'($urandom_range(2)));
    meas(2'h3, 3'($urandom_range(2)));
    fin("prescale");
    wr(a_sc, 8'h08);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      if (k) dbg <= 1;
      else clk_en <= 0;
      @(posedge clk);
      v = cnt;
      repeat (10) @(posedge clk);
      chk(cnt, v);
      clk_en <= 1;
    end
    rchk(a_ch, v[15:8]);
    rchk(a_cl, v[7:0]);
    dbg <= 0;
    wr(a_ch, 8'($urandom));
    chk(cnt < 16'h8, 1'b1);
    pair(1'b0);
    pair(1'b1);
    rdr(a_ch);
    wr(a_sc, 8'h08);
    pair(1'b1);
    fin("coherency");
    m = 16'($urandom_range(40, 12));
    wr(a_mh, 8'h00);
    wr(a_ml, m[7:0]);
    wr(a_cl, 8'($urandom));
    chk(irq, 1'b0);
    wr(a_sc, 8'h48);
    ovf(16'h0);
    rdr(a_sc);
    ovf(16'h0);
    wr(a_sc, 8'h48);
    rchk(a_sc, 8'hc8);
    wr(a_sc, 8'hc0);
    chk(irq, 1'b1);
    rchk(a_sc, 8'hc0);
    wr(a_sc, 8'h40);
    chk(irq, 1'b0);
    rchk(a_sc, 8'h40);
    fin("overflow");
    // Restarting the stopped counter first keeps a short modulo from rolling before the write.
    wr(a_cl, 8'h00);
    wr(a_sc, 8'h48);
    wr(a_ml, m[7:0] + 8'h3);
    repeat (120) @(posedge clk);
    chk(irq, 1'b0);
    rchk(a_ml, m[7:0]);
    wr(a_mh, 8'h00);
    m = m + 16'h3;
    ovf(16'h0);
    wr(a_sc, 8'h40);
    rdr(a_sc);
    wr(a_sc, 8'h00);
    fin("modulo");
    wr(a_cl, 8'h00);
    wr(a_sc, 8'h68);
    chk(ctr, 1'b1);
    ovf(m - 16'h1);
    @(posedge clk);
    chk(cnt, m - 16'h2);
    wr(a_sc, 8'h00);
    chk(ctr, 1'b0);
    fin("centre");
    final_report;
  end
endmodule // tpc_timer_core_tb
